/* File: hdl/udscr_regs.v */
// status fifo, control, address and frame number registers of the usb engine
// assumes same-clock engine event strobes and a cpu port with select index and strobes
`timescale 1ns/100ps
`default_nettype none
`include "udscr_map.vh"
module udscr_regs #(
    parameter DEPTH = `UDSCR_FIFO_DEPTH
) (
    input wire core_clk,
    input wire rstn,
    input wire [2:0] reg_idx,
    input wire reg_wr,
    input wire [7:0] reg_wdata,
    output reg [7:0] reg_rdata,
    input wire token_done_clear,
    output reg token_done_flag,
    input wire bd_done,
    input wire [3:0] bd_endpoint,
    input wire bd_is_in,
    input wire bd_is_odd,
    output wire fifo_full,
    input wire setup_seen,
    input wire sof_seen,
    input wire [10:0] sof_frame,
    input wire bus_reset_seen,
    output wire token_hold_bit,
    output wire remote_wakeup_bit,
    output wire pingpong_clear,
    output wire module_enable_bit,
    output wire engine_reset,
    output wire [6:0] node_addr
);
// ****************************************
// status fifo
// ****************************************
reg [7:0] fifo_mem [0:DEPTH-1];
reg [1:0] wr_ptr;
reg [1:0] rd_ptr;
reg [2:0] count;
reg [7:0] result;
wire [7:0] push_entry = {bd_endpoint, bd_is_in, bd_is_odd, 2'b00};
wire pop_req = token_done_clear & token_done_flag;
wire have_next = (count != 3'h0);
localparam [2:0] LAST = DEPTH[2:0] - 3'h1;
// the visible result is the head entry, so full means the flag plus DEPTH-1 queued
assign fifo_full = token_done_flag & (count == LAST);
wire push = bd_done & ~fifo_full;
// a push that meets a clear of the last entry is exposed at once, so the set wins
wire direct = push & ~have_next & (~token_done_flag | pop_req);
wire pop = (pop_req | ~token_done_flag) & have_next;
wire do_write = push & ~direct;
always @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
        wr_ptr <= 2'h0;
        rd_ptr <= 2'h0;
        count <= 3'h0;
        result <= 8'h00;
        token_done_flag <= 1'b0;
    end else if (engine_reset) begin
        wr_ptr <= 2'h0;
        rd_ptr <= 2'h0;
        count <= 3'h0;
        token_done_flag <= 1'b0;
    end else begin
        if (do_write) begin
            fifo_mem[wr_ptr] <= push_entry;
            wr_ptr <= wr_ptr + 2'h1;
        end
        if (pop) begin
            result <= fifo_mem[rd_ptr];
            rd_ptr <= rd_ptr + 2'h1;
        end else if (direct) begin
            result <= push_entry;
        end
        count <= count + {2'b00, do_write} - {2'b00, pop};
        if (pop | direct)
            token_done_flag <= 1'b1;
        else if (pop_req)
            token_done_flag <= 1'b0;
    end
end
// ****************************************
// control, address, frame
// ****************************************
reg hold;
reg wake;
reg pingpong_clear_bit;
reg enable;
reg [6:0] addr;
reg [10:0] frame;
wire wr_ctrl = reg_wr & (reg_idx == `UDSCR_IDX_CTRL);
wire wr_addr = reg_wr & (reg_idx == `UDSCR_IDX_ADDR);
always @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
        hold <= 1'b0;
        wake <= 1'b0;
        pingpong_clear_bit <= 1'b0;
        enable <= 1'b0;
        addr <= `UDSCR_ADDR_RESET;
        frame <= 11'h000;
    end else begin
        if (setup_seen)
            hold <= 1'b1;
        else if (wr_ctrl)
            hold <= reg_wdata[`UDSCR_CTRL_HOLD];
        if (wr_ctrl) begin
            wake <= reg_wdata[`UDSCR_CTRL_WAKE];
            pingpong_clear_bit <= reg_wdata[`UDSCR_CTRL_PINGPONG_CLEAR_BIT];
            enable <= reg_wdata[`UDSCR_CTRL_EN];
        end
        if (bus_reset_seen)
            addr <= `UDSCR_ADDR_RESET;
        else if (wr_addr)
            addr <= reg_wdata[6:0];
        if (sof_seen)
            frame <= sof_frame;
    end
end
reg enable_d;
always @(posedge core_clk or negedge rstn) begin
    if (!rstn)
        enable_d <= 1'b0;
    else
        enable_d <= enable;
end
assign engine_reset = enable & ~enable_d;
assign pingpong_clear = pingpong_clear_bit | engine_reset;
assign token_hold_bit = hold;
assign remote_wakeup_bit = wake & enable;
assign module_enable_bit = enable;
assign node_addr = addr;
// ****************************************
// read mux
// ****************************************
always @* begin
    case (reg_idx)
        `UDSCR_IDX_RESULT: reg_rdata = result;
        `UDSCR_IDX_CTRL: reg_rdata = {2'b00, hold, 2'b00, wake, pingpong_clear_bit, enable};
        `UDSCR_IDX_ADDR: reg_rdata = {1'b0, addr};
        `UDSCR_IDX_FRML: reg_rdata = frame[7:0];
        `UDSCR_IDX_FRMH: reg_rdata = {5'b00000, frame[10:8]};
        default: reg_rdata = 8'h00;
    endcase
end
endmodule // udscr_regs
`default_nettype wire

/* File: hdl/udscr_map.vh */
// register map, field positions and reset values for the usb status/control registers
// assumes an 8-bit cpu register port with a per-register select index
// Behaviour
// - result register meaningful only while token-done flag is set
// - push a result entry per finished descriptor into a four-deep fifo
// - clearing token-done loads the visible result with the next queued entry
// - if the next entry is valid, token-done sets again at once
// - result bits 7..4 hold endpoint number 0 to 15
// - result bit 3 is one for in transfers, zero for out
// - result bit 2 is one for odd bank, zero for even bank
// - setup token sets control bit 5 and holds packet traffic
// - control bit 2 drives resume signaling while set and control bit 0 is set
// - control bit 1 forces all ping-pong bits to even bank
// - control bit 0 enables module; setting it resets ping-pong bits and engine
// - address register bits 6..0 give the decoded bus address
// - address register clears on system reset and usb bus reset
// - each sof token captures the 11-bit frame number
// - low frame register bits 7..0, high register bits 2..0 hold bits 10..8
`ifndef UDSCR_MAP_VH
`define UDSCR_MAP_VH
`define UDSCR_IDX_RESULT 3'h0
`define UDSCR_IDX_CTRL 3'h1
`define UDSCR_IDX_ADDR 3'h2
`define UDSCR_IDX_FRML 3'h3
`define UDSCR_IDX_FRMH 3'h4
`define UDSCR_CTRL_HOLD 5
`define UDSCR_CTRL_WAKE 2
`define UDSCR_CTRL_PINGPONG_CLEAR_BIT 1
`define UDSCR_CTRL_EN 0
`define UDSCR_CTRL_MASK 8'h27
`define UDSCR_ADDR_MASK 8'h7f
`define UDSCR_ADDR_RESET 7'h00
`define UDSCR_FIFO_DEPTH 4
`endif

/* File: bench/udscr_chk.sv */
// port checker for udscr_regs
// assumes binding onto udscr_regs
`timescale 1ns/100ps
`default_nettype none
module udscr_chk(input wire core_clk, rstn, reg_wr, bd_done, sof_seen, setup_seen, bus_reset_seen,
    input wire [2:0] reg_idx, input wire [7:0] reg_wdata, reg_rdata, input wire [10:0] sof_frame,
    input wire fifo_full, token_done_flag, token_hold_bit, remote_wakeup_bit, module_enable_bit,
    input wire pingpong_clear, engine_reset, input wire [6:0] node_addr);
default clocking @(posedge core_clk); endclocking
default disable iff (!rstn);
sequence s_sof_low; sof_seen ##1 (reg_idx == 3'h3 && !sof_seen); endsequence
a_setup_hold: assert property (setup_seen |=> token_hold_bit) else $error("hold");
a_addr_clear: assert property (bus_reset_seen |=> node_addr == 7'h00) else $error("addr");
a_addr_write: assert property (reg_wr && reg_idx == 3'h2 && !bus_reset_seen
    |=> node_addr == $past(reg_wdata[6:0])) else $error("addr wr");
a_push_flag: assert property (bd_done && !fifo_full && !engine_reset |=> token_done_flag)
    else $error("flag");
a_frame_low: assert property (s_sof_low |-> reg_rdata == $past(sof_frame[7:0])) else $error("frm");
a_unmapped_zero: assert property (reg_idx > 3'h4 |-> reg_rdata == 8'h00) else $error("unm");
a_result_low: assert property (reg_idx == 3'h0 |-> reg_rdata[1:0] == 2'h0) else $error("res");
a_wake_gate: assert property (remote_wakeup_bit |-> module_enable_bit) else $error("wake");
a_reset_even: assert property (engine_reset |-> pingpong_clear) else $error("odd");
endmodule // udscr_chk
bind udscr_regs udscr_chk chk(.*);
`default_nettype wire

/* File: bench/udscr_eng.sv */
// engine and token decode event source
// assumes the bench calls its tasks
`timescale 1ns/100ps
`default_nettype none
module udscr_eng(input wire core_clk, output logic bd_done = 0, bd_is_in = 0, bd_is_odd = 0,
    output logic setup_seen = 0, sof_seen = 0, bus_reset_seen = 0,
    output logic [3:0] bd_endpoint = 0, output logic [10:0] sof_frame = 0);
task push(input [3:0] e, input i, o);
    @(negedge core_clk) {bd_done, bd_endpoint, bd_is_in, bd_is_odd} = {1'b1, e, i, o};
endtask
task stop;
    @(negedge core_clk) {bd_done, bd_endpoint, bd_is_in, bd_is_odd} = {1'b0, ~bd_endpoint, ~bd_is_in, ~bd_is_odd};
    @(posedge core_clk);
endtask
task pulse(input s, b, f, input [10:0] n);
    @(negedge core_clk) {setup_seen, bus_reset_seen, sof_seen, sof_frame} = {s, b, f, n};
    @(negedge core_clk) {setup_seen, bus_reset_seen, sof_seen, sof_frame} = {3'h0, ~n};
    @(posedge core_clk);
endtask
endmodule // udscr_eng
`default_nettype wire

/* File: bench/udscr_regs_tb_top.sv */
// testbench for udscr_regs
// assumes udscr_eng and the checker compiled first
`timescale 1ns/100ps
`default_nettype none
module udscr_regs_tb_top;
logic core_clk = 0, rstn = 0, reg_wr = 0, token_done_clear = 0;
logic [2:0] reg_idx = 0;
logic [7:0] reg_wdata = 0;
logic [7:0] exp_q [4] = '{8'h08, 8'h64, 8'h5c, 8'h30};
wire [7:0] reg_rdata;
wire [3:0] ep;
wire [10:0] fr;
wire [6:0] node_addr;
wire dn, ii, od, su, sf, br, full, flag, hold, wake, ppc, en, er;
int num_errors = 0, comparisons = 0, k;
udscr_eng eng(.core_clk, .bd_done(dn), .bd_endpoint(ep), .bd_is_in(ii), .bd_is_odd(od), .setup_seen(su),
    .sof_seen(sf), .bus_reset_seen(br), .sof_frame(fr));
udscr_regs dut(.core_clk, .rstn, .reg_idx, .reg_wr, .reg_wdata, .reg_rdata, .token_done_clear,
    .token_done_flag(flag), .bd_done(dn), .bd_endpoint(ep), .bd_is_in(ii), .bd_is_odd(od), .fifo_full(full),
    .setup_seen(su), .sof_seen(sf), .sof_frame(fr), .bus_reset_seen(br), .token_hold_bit(hold),
    .remote_wakeup_bit(wake), .pingpong_clear(ppc), .module_enable_bit(en), .engine_reset(er), .node_addr);
initial forever #5 core_clk = ~core_clk;
task cmp(input logic [7:0] got, exp);
    comparisons++;
    if (got !== exp) begin
        num_errors++;
        $display("ERROR %0t got %h exp %h", $time, got, exp);
    end
endtask
task wr(input [2:0] i, input [7:0] d);
    @(negedge core_clk) {reg_idx, reg_wdata, reg_wr} = {i, d, 1'b1};
    @(negedge core_clk) reg_wr = 0;
    @(posedge core_clk);
endtask
task rd(input [2:0] i, input [7:0] e);
    @(negedge core_clk) reg_idx = i;
    #1 cmp(reg_rdata, e);
endtask
task clr;
    @(negedge core_clk) token_done_clear = 1;
    @(negedge core_clk) token_done_clear = 0;
    @(posedge core_clk);
endtask
task report_and_stop;
    $display("errors %0d comparisons %0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0)
        $display("TEST PASSED");
    else
        $display("TEST FAILED");
    $finish;
endtask
initial begin
    #20000 num_errors++;
    report_and_stop;
end
initial begin
    repeat (4) @(posedge core_clk);
    @(negedge core_clk) rstn = 1;
    rd(3'h2, 8'h00);
    rd(3'h7, 8'h00);
    wr(3'h1, 8'hc5); rd(3'h1, 8'h05);
    cmp({7'h0, wake}, 8'h01);
    wr(3'h1, 8'h03); cmp({7'h0, wake, ppc}, 8'h01);
    wr(3'h1, 8'h01);
    eng.push(4'h0, 1, 0); eng.push(4'h6, 0, 1); eng.push(4'h5, 1, 1); eng.push(4'h3, 0, 0);
    eng.push(4'h1, 1, 1); eng.stop; cmp({7'h0, full}, 8'h01);
    for (k = 0; k < 4; k++) begin
        cmp({7'h0, flag}, 8'h01); rd(3'h0, exp_q[k]); clr;
    end
    cmp({7'h0, flag}, 8'h00);
    eng.pulse(1, 0, 0, 11'h0); rd(3'h1, 8'h21);
    wr(3'h1, 8'h01); rd(3'h1, 8'h01);
    wr(3'h2, 8'hff); rd(3'h2, 8'h7f);
    eng.pulse(0, 1, 0, 11'h0); rd(3'h2, 8'h00);
    rd(3'h3, 8'h00);
    eng.pulse(0, 0, 1, 11'h5a3); rd(3'h3, 8'ha3); rd(3'h4, 8'h05);
    report_and_stop;
end
endmodule // udscr_regs_tb_top
`default_nettype wire
